/* pkg/tss_pkg.sv */
// =====================================================================
// Shared constants for the transmit symbol serializer timing block
package tss_pkg;
   // =====================================================================
   // Register offsets on the special-function register port
   localparam logic [7:0] TSS_ADDR_TIMING = 8'hAA; // Serializer timing
   localparam logic [7:0] TSS_ADDR_DATA = 8'hAB; // Symbol group data
   localparam logic [7:0] TSS_ADDR_RATE_LO = 8'hAC; // Symbol rate low
   localparam logic [7:0] TSS_ADDR_RATE_HI = 8'hAD; // Symbol rate high
   localparam logic [7:0] TSS_ADDR_WARM = 8'hAE; // Divider and amp warm-up
   localparam logic [7:0] TSS_RESET_BYTE = 8'h00; // Reset value of all registers

   // =====================================================================
   // Field positions
   localparam int TSS_GROUP_HI = 7; // Group width field
   localparam int TSS_GROUP_LO = 5;
   localparam int TSS_EDGE_HI = 4; // Edge time field
   localparam int TSS_EDGE_LO = 3;
   localparam int TSS_DIV_HI = 2; // Clock divisor field
   localparam int TSS_DIV_LO = 0;
   localparam int TSS_WDIV_HI = 7; // Divider warm-up field
   localparam int TSS_WDIV_LO = 4;
   localparam int TSS_WAMP_HI = 3; // Amp warm-up field
   localparam int TSS_WAMP_LO = 0;
   localparam logic [7:0] TSS_RATE_HI_MASK = 8'h7F; // Bit 7 reads zero

   // =====================================================================
   // Timing multipliers, in serializer clocks
   localparam int TSS_RAMP_FACTOR = 8; // Ramp ticks per edge step
   localparam int TSS_DIV_WARM_SHIFT = 2; // Divider warm-up x4
   localparam int TSS_OSC_WARM_SHIFT = 6; // Oscillator warm-up x64

   // =====================================================================
   // End-of-data behaviour codes
   localparam logic [1:0] TSS_END_STOP = 2'h0; // Shut down RF chain
   localparam logic [1:0] TSS_END_REPEAT = 2'h1; // Reuse last group
   localparam logic [1:0] TSS_END_ZEROS = 2'h2; // All zero symbols
   localparam logic [1:0] TSS_END_ONES = 2'h3; // All one symbols

   // Buffer word: group width above the data byte
   localparam int TSS_BUF_W = 11;

   typedef enum logic [1:0] {TSS_IDLE, TSS_WARM, TSS_RUN} tss_state_t;
endpackage

/* pkg/tss_buf_if.sv */
`timescale 1ns/1ns
// =====================================================================
// Carrier between the register side and the two-entry group buffer
interface tss_buf_if;
   logic pushValid; // Byte waiting in holding register
   logic pushReady; // Buffer has room
   logic [tss_pkg::TSS_BUF_W-1:0] pushData; // Width and byte
   logic popValid; // Buffer holds a group
   logic popReady; // Serializer takes the group
   logic [tss_pkg::TSS_BUF_W-1:0] popData; // Oldest group
   modport source (output pushValid, output pushData, input pushReady,
                   input popValid, input popData, output popReady);
   modport store (input pushValid, input pushData, output pushReady,
                  output popValid, output popData, input popReady);
endinterface

/* design/tss_group_buffer.sv */
`timescale 1ns/1ns
// =====================================================================
// Two-entry group buffer; words are held in flip-flops
module tss_group_buffer (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Buffer carrier
   tss_buf_if.store bufPort
);
   import tss_pkg::*;

   // All state of the buffer
   typedef struct packed {
      logic [1:0][TSS_BUF_W-1:0] mem; // Two stored words
      logic wrPtr; // Next slot to fill
      logic rdPtr; // Oldest slot
      logic [1:0] count; // Words held
   } tss_buf_t;

   tss_buf_t s;
   tss_buf_t next_s;
   logic doPush;
   logic doPop;

   // Honest flags straight from the count
   assign bufPort.pushReady = (s.count != 2'h2);
   assign bufPort.popValid = (s.count != 2'h0);
   assign bufPort.popData = s.mem[s.rdPtr];

   // Next-state logic; push and pop may share a cycle
   always_comb begin
      next_s = s;
      doPush = bufPort.pushValid && bufPort.pushReady;
      doPop = bufPort.popValid && bufPort.popReady;
      if (doPush) begin
         next_s.mem[s.wrPtr] = bufPort.pushData;
         next_s.wrPtr = ~s.wrPtr;
      end
      if (doPop) begin
         next_s.rdPtr = ~s.rdPtr;
      end
      // Count moves only when exactly one side acts
      if (doPush && !doPop) begin
         next_s.count = s.count + 2'h1;
      end else if (doPop && !doPush) begin
         next_s.count = s.count - 2'h1;
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

/* design/tss_serializer_timing.sv */
`timescale 1ns/1ns
// How it works
// - Group length is width field plus one
// - Edge field adds division factor one-four
// - Clock divisor field divides system clock
// - Data write clears empty flag unless a group load in the same cycle sets it
// - Bit 0 of each group sent first
// - Rate is fifteen bits, low plus high
// - One symbol per rate serializer clocks
// - High rate bit 7 reads zero
// - Divider biased four times field clocks early
// - Amp biased field clocks early
// - End-of-data action from two-bit setting
// - Oscillator biased sixty-four times field early
module tss_serializer_timing (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Special-function register port
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic [7:0] sfrWrData,
   output logic [7:0] sfrRdData,
   // Control kept outside this block
   input wire logic serializerEnable,
   input wire logic fskMode,
   input wire logic [1:0] endOfDataMode,
   input wire logic [3:0] oscillator_warmup_count,
   // RF chain and status
   output logic lc_oscillatorBias,
   output logic dividerBias,
   output logic power_ampBias,
   output logic power_ampOn,
   output logic power_ampRamping,
   output logic txSymbol,
   output logic txActive,
   output logic emptyFlag,
   output logic dataNotify
);
   import tss_pkg::*;

   // =====================================================================
   // State
   typedef struct packed {
      logic [7:0] timing; // Serializer timing register
      logic [7:0] holdData; // Symbol group holding register
      logic [2:0] holdWidth; // Width captured with the byte
      logic [7:0] rate_low_byte; // Rate bits 7:0
      logic [6:0] rate_high_bits; // Rate bits 14:8
      logic [7:0] warm; // Divider and amp warm-up register
      logic notify; // Write pulse toward serializer
      logic pending; // Held byte not yet in buffer
      logic empty; // Software may write next group
      logic [2:0] ckCnt; // Serializer clock divider
      tss_state_t state; // Serializer phase
      logic [14:0] warmRem; // Warm-up ticks left
      logic [14:0] rateCnt; // Ticks within current symbol
      logic [7:0] shiftReg; // Group being sent
      logic [2:0] lastIdx; // Index of the final symbol
      logic [2:0] bitIdx; // Current symbol index
      logic symbol; // Symbol on the air
      logic oscOn; // Oscillator bias
      logic divOn; // Divider bias
      logic ampBias; // Amp bias
      logic ampOn; // Amp drive target
      logic [5:0] rampCnt; // Ramp ticks left
      logic [7:0] rdData; // Read data register
   } tss_top_t;

   tss_top_t s;
   tss_top_t next_s;
   tss_buf_if bufBus ();

   // Group buffer; a full buffer holds the byte in the holding register
   tss_group_buffer i_tss_group_buffer (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .bufPort(bufBus.store)
   );

   // =====================================================================
   // Helpers
   // Field value plus one, as a count
   function automatic logic [3:0] plusOne(input logic [2:0] f);
      return {1'b0, f} + 4'h1;
   endfunction

   // A warm-up is due once the ticks left fall to its interval
   function automatic logic due(input logic [14:0] rem, input logic [14:0] thr);
      return (thr != 15'h0) && (rem <= thr);
   endfunction

   // Combinational working values
   logic serTick;
   logic [2:0] ckDiv;
   logic [14:0] rate;
   logic [14:0] lcThr;
   logic [14:0] divThr;
   logic [14:0] ampThr;
   logic [14:0] warmTotal;
   logic [14:0] remain;
   logic doLoad;
   logic nextSym;
   logic symOn;

   assign bufBus.pushValid = s.pending;
   assign bufBus.pushData = {s.holdWidth, s.holdData};
   assign bufBus.popReady = doLoad;

   // Register outputs
   assign sfrRdData = s.rdData;
   assign lc_oscillatorBias = s.oscOn;
   assign dividerBias = s.divOn;
   assign power_ampBias = s.ampBias;
   assign power_ampOn = s.ampOn;
   assign power_ampRamping = (s.rampCnt != 6'h0);
   assign txSymbol = s.symbol;
   assign txActive = (s.state != TSS_IDLE);
   assign emptyFlag = s.empty;
   assign dataNotify = s.notify;

   // =====================================================================
   // Next-state logic
   always_comb begin
      next_s = s;
      doLoad = 1'b0;
      ckDiv = s.timing[TSS_DIV_HI:TSS_DIV_LO];
      serTick = (s.ckCnt >= ckDiv);
      rate = {s.rate_high_bits, s.rate_low_byte};
      // A zero rate behaves as one tick per symbol
      if (rate == 15'h0) begin
         rate = 15'h1;
      end
      lcThr = 15'(oscillator_warmup_count) << TSS_OSC_WARM_SHIFT;
      divThr = 15'(s.warm[TSS_WDIV_HI:TSS_WDIV_LO]) << TSS_DIV_WARM_SHIFT;
      ampThr = {11'h0, s.warm[TSS_WAMP_HI:TSS_WAMP_LO]};
      warmTotal = lcThr;
      if (divThr > warmTotal) begin
         warmTotal = divThr;
      end
      if (ampThr > warmTotal) begin
         warmTotal = ampThr;
      end
      next_s.notify = 1'b0;
      // Serializer clock divider
      next_s.ckCnt = serTick ? 3'h0 : s.ckCnt + 3'h1;
      // Register writes
      if (sfrWr) begin
         if (sfrAddr == TSS_ADDR_TIMING) begin
            next_s.timing = sfrWrData;
         end else if (sfrAddr == TSS_ADDR_DATA) begin
            next_s.holdData = sfrWrData;
            next_s.holdWidth = s.timing[TSS_GROUP_HI:TSS_GROUP_LO];
            next_s.notify = 1'b1;
            next_s.empty = 1'b0;
         end else if (sfrAddr == TSS_ADDR_RATE_LO) begin
            next_s.rate_low_byte = sfrWrData;
         end else if (sfrAddr == TSS_ADDR_RATE_HI) begin
            next_s.rate_high_bits = sfrWrData[6:0];
         end else if (sfrAddr == TSS_ADDR_WARM) begin
            next_s.warm = sfrWrData;
         end
      end
      // Notify pulse moves the stable byte toward the buffer
      if (s.notify) begin
         next_s.pending = 1'b1;
      end else if (s.pending && bufBus.pushReady) begin
         next_s.pending = 1'b0;
      end
      // Serializer sequence, one step per serializer clock
      if (!serializerEnable) begin
         next_s.state = TSS_IDLE;
      end else if (serTick) begin
         case (s.state)
            TSS_IDLE: begin
               if (bufBus.popValid) begin
                  if (warmTotal == 15'h0) begin
                     doLoad = 1'b1;
                  end else begin
                     next_s.state = TSS_WARM;
                     next_s.warmRem = warmTotal;
                  end
               end
            end
            TSS_WARM: begin
               if (s.warmRem <= 15'h1) begin
                  doLoad = 1'b1;
               end else begin
                  next_s.warmRem = s.warmRem - 15'h1;
               end
            end
            TSS_RUN: begin
               if (s.rateCnt + 15'h1 >= rate) begin
                  next_s.rateCnt = 15'h0;
                  if (s.bitIdx != s.lastIdx) begin
                     next_s.bitIdx = s.bitIdx + 3'h1;
                     next_s.symbol = s.shiftReg[next_s.bitIdx];
                  end else if (bufBus.popValid) begin
                     doLoad = 1'b1;
                  end else begin
                     next_s.bitIdx = 3'h0;
                     case (endOfDataMode)
                        TSS_END_STOP: next_s.state = TSS_IDLE;
                        TSS_END_REPEAT: next_s.shiftReg = s.shiftReg;
                        TSS_END_ZEROS: next_s.shiftReg = 8'h00;
                        default: next_s.shiftReg = 8'hFF;
                     endcase
                     next_s.symbol = next_s.shiftReg[0];
                  end
               end else begin
                  next_s.rateCnt = s.rateCnt + 15'h1;
               end
            end
            default: next_s.state = TSS_IDLE;
         endcase
      end
      // Group enters the shifter
      if (doLoad) begin
         next_s.state = TSS_RUN;
         next_s.shiftReg = bufBus.popData[7:0];
         next_s.lastIdx = bufBus.popData[10:8];
         next_s.bitIdx = 3'h0;
         next_s.rateCnt = 15'h0;
         next_s.symbol = bufBus.popData[0];
         next_s.empty = 1'b1;
      end
      // Symbol after the current one, for OOK lead-in
      if (next_s.bitIdx != next_s.lastIdx) begin
         nextSym = next_s.shiftReg[next_s.bitIdx + 3'h1];
      end else if (bufBus.popValid) begin
         nextSym = bufBus.popData[0];
      end else begin
         nextSym = (endOfDataMode == TSS_END_REPEAT) ? next_s.shiftReg[0] :
                   (endOfDataMode == TSS_END_ONES);
      end
      remain = rate - next_s.rateCnt;
      symOn = fskMode || next_s.symbol;
      // Power sequencing of the RF chain
      if (next_s.state == TSS_RUN) begin
         // OOK zero followed by one warms up ahead of the edge
         next_s.oscOn = symOn || (nextSym && due(remain, lcThr));
         next_s.divOn = symOn || (nextSym && due(remain, divThr));
         next_s.ampBias = symOn || (nextSym && due(remain, ampThr));
         next_s.ampOn = symOn;
      end else if (next_s.state == TSS_WARM) begin
         next_s.oscOn = due(next_s.warmRem, lcThr);
         next_s.divOn = due(next_s.warmRem, divThr);
         next_s.ampBias = due(next_s.warmRem, ampThr);
         next_s.ampOn = 1'b0;
      end else begin
         next_s.oscOn = 1'b0;
         next_s.divOn = 1'b0;
         next_s.ampBias = 1'b0;
         next_s.ampOn = 1'b0;
      end
      // Amp edge shaping, counted in serializer clocks
      if (next_s.ampOn != s.ampOn) begin
         next_s.rampCnt = 6'(TSS_RAMP_FACTOR *
                          plusOne({1'b0, s.timing[TSS_EDGE_HI:TSS_EDGE_LO]}));
      end else if (serTick && s.rampCnt != 6'h0) begin
         next_s.rampCnt = s.rampCnt - 6'h1;
      end
      // Registered read data; unmapped addresses read zero
      if (sfrAddr == TSS_ADDR_TIMING) begin
         next_s.rdData = s.timing;
      end else if (sfrAddr == TSS_ADDR_DATA) begin
         next_s.rdData = s.holdData;
      end else if (sfrAddr == TSS_ADDR_RATE_LO) begin
         next_s.rdData = s.rate_low_byte;
      end else if (sfrAddr == TSS_ADDR_RATE_HI) begin
         next_s.rdData = {1'b0, s.rate_high_bits} & TSS_RATE_HI_MASK;
      end else if (sfrAddr == TSS_ADDR_WARM) begin
         next_s.rdData = s.warm;
      end else begin
         next_s.rdData = 8'h00;
      end
   end

   // =====================================================================
   // State register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s <= '0;
         s.timing <= TSS_RESET_BYTE;
         s.empty <= 1'b1;
      end else begin
         s <= next_s;
      end
   end
endmodule

/* tb/tss_serializer_timing_sva.sv */
`timescale 1ns/1ns
// =====================================================================
// Port-level checks for the serializer timing block
module tss_serializer_timing_sva (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic [7:0] sfrWrData,
   input wire logic [7:0] sfrRdData,
   // RF chain and status
   input wire logic power_ampBias,
   input wire logic power_ampOn,
   input wire logic power_ampRamping,
   input wire logic txActive,
   input wire logic emptyFlag,
   input wire logic dataNotify
);
   import tss_pkg::*;
   // Data write as seen at the port
   wire logic wrData = sfrWr && (sfrAddr == TSS_ADDR_DATA);

   // =====================================================================
   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   notify_after_write_a: assert property (wrData |=> dataNotify)
      else $error("no notify pulse after a data write");
   notify_has_cause_a: assert property (dataNotify |-> $past(wrData))
      else $error("notify pulse without a data write");
   // Idle with an empty pipeline, so nothing can set the flag again
   empty_clear_a: assert property (wrData && emptyFlag && !txActive |=> !emptyFlag)
      else $error("empty flag not cleared by a data write");
   rate_bit7_a: assert property (sfrAddr == TSS_ADDR_RATE_HI |=> !sfrRdData[7])
      else $error("rate high bit 7 read as one");
   timing_readback_a: assert property (
      (sfrWr && sfrAddr == TSS_ADDR_TIMING) ##1 (!sfrWr && sfrAddr == TSS_ADDR_TIMING)
      |=> sfrRdData == $past(sfrWrData, 2)) else $error("timing register readback wrong");
   empty_set_a: assert property ($rose(emptyFlag) |-> txActive)
      else $error("empty flag set without a group load");
   ramp_start_a: assert property ($changed(power_ampOn) |-> ##[0:1] power_ampRamping)
      else $error("no ramp after amp drive change");
   amp_bias_on_a: assert property ($rose(power_ampOn) |-> ##[0:1] power_ampBias)
      else $error("amp driven without bias");
endmodule

bind tss_serializer_timing tss_serializer_timing_sva i_tss_serializer_timing_sva (
   .ref_clk, .sys_rst, .sfrAddr, .sfrWr, .sfrWrData, .sfrRdData, .power_ampBias,
   .power_ampOn, .power_ampRamping, .txActive, .emptyFlag, .dataNotify
);

/* tb/tss_rf_model.sv */
`timescale 1ns/1ns
// =====================================================================
// RF chain stand-in: measures bias lead times and ramp lengths
module tss_rf_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Chain controls from the block
   input wire logic lc_oscillatorBias,
   input wire logic dividerBias,
   input wire logic power_ampBias,
   input wire logic power_ampOn,
   input wire logic power_ampRamping,
   // Measured figures, in system clocks
   output logic [15:0] oscLead,
   output logic [15:0] divLead,
   output logic [15:0] ampLead,
   output logic [15:0] rampLen
);
   logic [15:0] oscCnt; // Clocks each bias has been up
   logic [15:0] divCnt;
   logic [15:0] ampCnt;
   logic [15:0] rampCnt; // Clocks of the current ramp
   logic onQ; // Amp drive one clock ago

   // =====================================================================
   // Counters restart when a bias drops, so each warm-up is timed afresh
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         {oscCnt, divCnt, ampCnt, rampCnt} <= '0;
         {oscLead, divLead, ampLead, rampLen} <= '0;
         onQ <= 1'b0;
      end else begin
         onQ <= power_ampOn;
         oscCnt <= lc_oscillatorBias ? oscCnt + 16'h0001 : 16'h0000;
         divCnt <= dividerBias ? divCnt + 16'h0001 : 16'h0000;
         ampCnt <= power_ampBias ? ampCnt + 16'h0001 : 16'h0000;
         rampCnt <= power_ampRamping ? rampCnt + 16'h0001 : 16'h0000;
         // Lead is latched at the clock the amp turns on
         if (power_ampOn && !onQ) begin
            oscLead <= oscCnt;
            divLead <= divCnt;
            ampLead <= ampCnt;
         end
         // Ramp length latched when it ends
         if (!power_ampRamping && rampCnt != 16'h0000) begin
            rampLen <= rampCnt;
         end
      end
   end
endmodule

/* tb/tb_tss_serializer_timing.sv */
`timescale 1ns/1ns
// =====================================================================
// Self-checking bench for the serializer timing block
module tb_tss_serializer_timing;
   import tss_pkg::*;
   // One run: timing byte, group byte, end mode, two symbols after group
   typedef struct packed {
      logic [7:0] timing;
      logic [7:0] data;
      logic [1:0] mode;
      logic [1:0] tail;
   } tss_row_t;
   tss_row_t rows [5] = '{
      '{8'hE9, 8'h4A, TSS_END_STOP, 2'h0}, '{8'hE9, 8'h4A, TSS_END_REPEAT, 2'h2},
      '{8'hE8, 8'h4A, TSS_END_ZEROS, 2'h0}, '{8'hEB, 8'h4A, TSS_END_ONES, 2'h3},
      '{8'h81, 8'hF0, TSS_END_ZEROS, 2'h0}};
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] sfrAddr = 8'h00;
   logic sfrWr = 1'b0;
   logic [7:0] sfrWrData = 8'h00;
   logic serializerEnable = 1'b0;
   logic fskMode = 1'b1; // FSK keeps the amp on while running
   logic [1:0] endOfDataMode = 2'h0;
   logic [3:0] oscillator_warmup_count = 4'h1;
   logic [7:0] sfrRdData, rv;
   logic lcBias, divBias, ampBias, ampOn, ampRamp;
   logic txSymbol, txActive, emptyFlag, dataNotify;
   logic [15:0] oscLead, divLead, ampLead, rampLen, expSyms;
   int errors = 0;
   int n_compared = 0;
   int dv, nsym;

   // =====================================================================
   // Clock, design and RF chain model
   always #5 ref_clk = ~ref_clk;
   tss_serializer_timing i_tss_serializer_timing (.ref_clk, .sys_rst, .sfrAddr, .sfrWr,
      .sfrWrData, .sfrRdData, .serializerEnable, .fskMode, .endOfDataMode,
      .oscillator_warmup_count, .lc_oscillatorBias(lcBias), .dividerBias(divBias),
      .power_ampBias(ampBias), .power_ampOn(ampOn), .power_ampRamping(ampRamp),
      .txSymbol, .txActive, .emptyFlag, .dataNotify);
   tss_rf_model i_tss_rf_model (.ref_clk, .sys_rst, .lc_oscillatorBias(lcBias),
      .dividerBias(divBias), .power_ampBias(ampBias), .power_ampOn(ampOn),
      .power_ampRamping(ampRamp), .oscLead, .divLead, .ampLead, .rampLen);

   // =====================================================================
   // Compare tasks: exact value, and value within a window
   task automatic chkv(input string name, input logic [15:0] exp, input logic [15:0] seen);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Window allows for register stages between tick and output
   task automatic chkr(input string name, input int c, input int tol, input logic [15:0] seen);
      n_compared++;
      if ((seen >= 16'(c - tol) && seen <= 16'(c + tol)) !== 1'b1) begin
         errors++;
         $display("[FAIL] %s expected %0d seen %0d", name, c, seen);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // =====================================================================
   // Register port: write taken at the second edge, read one edge later
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfrAddr <= a;
      sfrWr <= 1'b1;
      sfrWrData <= d;
      @(posedge ref_clk);
      sfrWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      sfrAddr <= a;
      @(posedge ref_clk);
      #1;
      d = sfrRdData;
   endtask
   // Data write, then its notify pulse lasts exactly one cycle
   task automatic wr_data(input logic [7:0] d);
      wr(TSS_ADDR_DATA, d);
      #1;
      chkv("dataNotify", 16'h1, 16'(dataNotify));
      chkv("emptyFlag", 16'h0, 16'(emptyFlag));
      @(posedge ref_clk);
      #1;
      chkv("dataNotify", 16'h0, 16'(dataNotify));
   endtask
   // Bounded wait for the group load
   task automatic wait_flag(input int lim);
      int k;
      k = 0;
      while (emptyFlag !== 1'b1 && k < lim) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      if (k >= lim) begin
         errors++;
         $display("[FAIL] emptyFlag expected 1 seen %b", emptyFlag);
         give_verdict();
      end
   endtask
   // Symbols sampled mid-period, so small latency shifts do not matter
   task automatic sample_syms(input int n, input int first, input int per,
                              input logic [15:0] exp);
      for (int i = 0; i < n; i++) begin
         repeat (i == 0 ? first : per) @(posedge ref_clk);
         #1;
         chkv("txSymbol", 16'(exp[i]), 16'(txSymbol));
      end
   endtask

   // =====================================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      wr(TSS_ADDR_RATE_LO, 8'h04);
      wr(TSS_ADDR_WARM, 8'h12);
      foreach (rows[i]) begin
         @(posedge ref_clk);
         serializerEnable <= 1'b0;
         endOfDataMode <= rows[i].mode;
         wr(TSS_ADDR_TIMING, rows[i].timing);
         serializerEnable <= 1'b1;
         wr_data(rows[i].data);
         wait_flag(700);
         dv = rows[i].timing[2:0] + 1;
         nsym = rows[i].timing[7:5] + 1;
         expSyms = (16'(rows[i].data) & ((16'h0001 << nsym) - 16'h0001))
                   | (16'(rows[i].tail) << nsym);
         sample_syms(nsym + 2, 2 * dv, 4 * dv, expSyms);
         chkr("oscLead", 64 * dv, dv + 1, oscLead);
         chkr("divLead", 4 * dv, dv + 1, divLead);
         chkr("ampLead", 2 * dv, dv + 1, ampLead);
         chkr("rampLen", 8 * (rows[i].timing[4:3] + 1) * dv, 2, rampLen);
         if (rows[i].mode === TSS_END_STOP) begin
            chkv("txActive", 16'h0, 16'(txActive));
         end
      end
      // OOK: biases rise again ahead of a zero-to-one symbol edge
      @(posedge ref_clk);
      serializerEnable <= 1'b0;
      fskMode <= 1'b0;
      endOfDataMode <= TSS_END_STOP;
      wr(TSS_ADDR_RATE_LO, 8'h50);
      wr(TSS_ADDR_TIMING, 8'h20);
      serializerEnable <= 1'b1;
      wr_data(8'h02);
      wait_flag(700);
      sample_syms(2, 40, 80, 16'h0002);
      chkr("oscLead", 64, 1, oscLead);
      chkr("divLead", 4, 1, divLead);
      chkr("ampLead", 2, 1, ampLead);
      // Shorter last group: width changed between two data writes
      @(posedge ref_clk);
      serializerEnable <= 1'b0;
      endOfDataMode <= TSS_END_ONES;
      wr(TSS_ADDR_RATE_LO, 8'h10);
      wr(TSS_ADDR_TIMING, 8'hE9);
      serializerEnable <= 1'b1;
      wr_data(8'h4A);
      wait_flag(700);
      wr(TSS_ADDR_TIMING, 8'h89);
      wr_data(8'h10);
      sample_syms(15, 11, 32, 16'h704A);
      // Second reset in mid-run, then register values and access kinds
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      #1;
      chkv("emptyFlag", 16'h1, 16'(emptyFlag));
      for (int a = 0; a < 5; a++) begin
         rd(TSS_ADDR_TIMING + 8'(a), rv);
         chkv("regReset", 16'h0, 16'(rv));
      end
      wr(TSS_ADDR_RATE_HI, 8'hFF);
      rd(TSS_ADDR_RATE_HI, rv);
      chkv("rateHigh", 16'h007F, 16'(rv));
      wr(TSS_ADDR_RATE_LO, 8'hA5);
      rd(TSS_ADDR_RATE_LO, rv);
      chkv("rateLow", 16'h00A5, 16'(rv));
      wr(TSS_ADDR_TIMING, 8'h5A);
      rd(TSS_ADDR_TIMING, rv);
      chkv("timing", 16'h005A, 16'(rv));
      // Unmapped address must leave the timing register alone
      wr(8'hB0, 8'hFF);
      rd(TSS_ADDR_TIMING, rv);
      chkv("unmapped", 16'h005A, 16'(rv));
      give_verdict();
   end
endmodule
